// *** rtl/irc_timer.v ***
// Purpose: 8-bit compare timer with PWM and infrared carrier modes
// Assumes: count clock is CLOCK_IN; envelope event comes from another domain
// Notes: Avalon-MM slave answers after one wait cycle
`timescale 1ns/100ps
`default_nettype none
`include "irc_defs.vh"
module irc_timer (
  // Clock and reset
  input wire CLOCK_IN,
  input wire RST_N_IN,
  // Avalon-MM slave
  input wire [4:0] AVS_ADDRESS_IN,
  input wire AVS_READ_IN,
  input wire AVS_WRITE_IN,
  input wire [31:0] AVS_WRITEDATA_IN,
  input wire [3:0] AVS_BYTEENABLE_IN,
  output wire [31:0] AVS_READDATA_OUT,
  output wire AVS_WAITREQUEST_OUT,
  // Envelope timer link
  input wire ENVELOPE_MATCH_EVENT_IN,
  output wire ENVELOPE_SYNC_EVENT_OUT,
  // Timer outputs
  output wire TIMER_OUTPUT_PIN_OUT,
  output wire COMPARE_MATCH_EVENT_OUT
);

  localparam ST_IDLE = 3'b001;
  localparam ST_HOLD = 3'b010;
  localparam ST_RUN = 3'b100;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg ack_q;
  reg [31:0] rdata_q;
  reg run_q;
  reg mode_q;
  reg remote_q;
  reg buffer_q;
  reg active_q;
  reg [7:0] cmp0_q;
  reg [7:0] cmp1_q;
  reg [7:0] duty_latch_q;
  reg pending_q;
  reg [1:0] age_q;
  reg [7:0] cnt_q;
  reg phase_q;
  reg wave_q;
  reg gate_q;
  reg pin_q;
  reg match_q;
  reg env_s1_q;
  reg env_s2_q;
  reg env_s3_q;
  reg env_lvl_q;
  reg sync_q;
  reg xfer_q;
  reg [7:0] cnt_d;
  reg phase_d;
  reg wave_d;
  reg gate_d;
  reg pin_d;
  reg match_d;
  reg load_duty;

  wire access = AVS_READ_IN | AVS_WRITE_IN;
  wire wr_go = AVS_WRITE_IN & ack_q & AVS_BYTEENABLE_IN[0];
  wire [7:0] wbyte = AVS_WRITEDATA_IN[7:0];
  wire wr_ctrl = wr_go & (AVS_ADDRESS_IN == `IRC_OFF_CTRL);
  wire wr_cmp0 = wr_go & (AVS_ADDRESS_IN == `IRC_OFF_CMP0);
  wire wr_cmp1 = wr_go & (AVS_ADDRESS_IN == `IRC_OFF_CMP1);
  wire wr_carr = wr_go & (AVS_ADDRESS_IN == `IRC_OFF_CARR);
  wire running = (state_q != ST_IDLE);
  wire cmp_hit = (state_q == ST_RUN) & (cnt_q == (phase_q ? cmp1_q : cmp0_q));
  wire env_rise = (env_s2_q == env_s3_q) & env_s3_q & ~env_lvl_q;

  assign AVS_WAITREQUEST_OUT = access & ~ack_q;
  assign AVS_READDATA_OUT = rdata_q;
  assign ENVELOPE_SYNC_EVENT_OUT = sync_q;
  assign TIMER_OUTPUT_PIN_OUT = pin_q;
  assign COMPARE_MATCH_EVENT_OUT = match_q;

  // Register read mux, zero for unmapped
  function [31:0] rd_mux;
    input [4:0] addr;
    begin
      case (addr)
        `IRC_OFF_CTRL: rd_mux = {30'h0, mode_q, run_q};
        `IRC_OFF_CMP0: rd_mux = {24'h0, cmp0_q};
        `IRC_OFF_CMP1: rd_mux = {24'h0, duty_latch_q};
        `IRC_OFF_CARR: rd_mux = {29'h0, remote_q, buffer_q, active_q}; // RULE_12 RULE_24
        `IRC_OFF_STAT: rd_mux = {15'h0, pending_q, cnt_q, 5'h0, phase_q, wave_q, pin_q};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  endfunction

  // Bus slave
  always @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      run_q <= 1'b0;
      mode_q <= 1'b0;
      remote_q <= 1'b0;
      buffer_q <= 1'b0;
      cmp0_q <= `IRC_RST_BYTE;
    end else begin
      ack_q <= access & ~ack_q;
      if (AVS_READ_IN & ~ack_q) begin
        rdata_q <= rd_mux(AVS_ADDRESS_IN);
      end
      if (wr_ctrl) begin
        run_q <= wbyte[`IRC_CTRL_RUN];
        mode_q <= wbyte[`IRC_CTRL_MODE];
      end
      if (wr_cmp0) begin
        cmp0_q <= wbyte;
      end
      if (wr_carr) begin
        buffer_q <= wbyte[`IRC_CARR_BUFFER]; // RULE_12
        remote_q <= wbyte[`IRC_CARR_REMOTE];
      end
    end
  end

  // Duty / high-width latch and transfer
  always @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      duty_latch_q <= `IRC_RST_BYTE;
      cmp1_q <= `IRC_RST_BYTE;
      pending_q <= 1'b0;
      age_q <= 2'h0;
    end else begin
      if (wr_cmp1) begin
        duty_latch_q <= wbyte; // RULE_04
        age_q <= 2'h0;
        pending_q <= running;
        if (!running) begin
          cmp1_q <= wbyte;
        end
      end else begin
        if (age_q != `IRC_DUTY_AGE_MIN) begin
          age_q <= age_q + 2'h1; // RULE_05
        end
        if (load_duty) begin
          cmp1_q <= duty_latch_q; // RULE_04
          pending_q <= 1'b0;
        end
      end
    end
  end

  // Envelope event synchroniser and transfer
  always @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      env_s1_q <= 1'b0;
      env_s2_q <= 1'b0;
      env_s3_q <= 1'b0;
      env_lvl_q <= 1'b0;
      sync_q <= 1'b0;
      xfer_q <= 1'b0;
      active_q <= 1'b0;
    end else begin
      env_s1_q <= ENVELOPE_MATCH_EVENT_IN; // RULE_13
      env_s2_q <= env_s1_q;
      env_s3_q <= env_s2_q;
      if (env_s2_q == env_s3_q) begin
        env_lvl_q <= env_s3_q;
      end
      sync_q <= env_rise; // RULE_13
      xfer_q <= sync_q;
      if (xfer_q) begin
        active_q <= buffer_q; // RULE_14
      end
    end
  end

  // Counter sequencing
  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    phase_d = phase_q;
    wave_d = wave_q;
    match_d = 1'b0;
    load_duty = 1'b0;
    case (state_q)
      ST_IDLE: begin
        cnt_d = 8'h00;
        phase_d = 1'b0;
        wave_d = 1'b0; // RULE_25
        if (run_q) begin
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        state_d = ST_RUN; // RULE_01
      end
      ST_RUN: begin
        cnt_d = cnt_q + `IRC_CNT_ONE;
        if (cmp_hit) begin
          wave_d = ~wave_q; // RULE_02 RULE_03 RULE_09
          phase_d = ~phase_q;
          load_duty = phase_q & pending_q & (age_q == `IRC_DUTY_AGE_MIN); // RULE_05
          if (mode_q) begin
            cnt_d = 8'h00; // RULE_07 RULE_09 RULE_10
            match_d = 1'b1;
          end else if (!phase_q) begin
            cnt_d = 8'h00; // RULE_02
            match_d = 1'b1;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (!run_q) begin
      state_d = ST_IDLE; // RULE_06
      match_d = 1'b0;
      wave_d = 1'b0;
    end
  end

  // Output selection
  always @* begin
    gate_d = gate_q;
    pin_d = 1'b0;
    if (!mode_q) begin
      pin_d = wave_d;
    end else begin
      if (active_q) begin
        gate_d = gate_q | (wave_d & ~wave_q); // RULE_17
      end else begin
        gate_d = gate_q & wave_d; // RULE_18
      end
      if (remote_q) begin
        pin_d = gate_d & wave_d; // RULE_11
      end else begin
        pin_d = active_q; // RULE_11
      end
    end
    if (!run_q) begin
      gate_d = 1'b0;
      pin_d = 1'b0; // RULE_06
    end
  end

  always @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_q <= ST_IDLE;
      cnt_q <= 8'h00;
      phase_q <= 1'b0;
      wave_q <= 1'b0;
      gate_q <= 1'b0;
      pin_q <= 1'b0;
      match_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      phase_q <= phase_d;
      wave_q <= wave_d;
      gate_q <= gate_d;
      pin_q <= pin_d;
      match_q <= match_d;
    end
  end

endmodule
`default_nettype wire

// *** rtl/irc_defs.vh ***
// Purpose: constants for the infrared carrier / PWM compare timer
// Assumes: byte addresses on a 32-bit Avalon-MM slave, one register a word
// Notes: data sits in the low byte except status count [15:8] and pending [16]; other bits read zero
// Functional notes
// RULE_01: On enable in PWM mode, hold counter one clock; output stays default.
// RULE_02: PWM period match clears counter, inverts output, raises match event.
// RULE_03: PWM duty match inverts output only; no clear, no event.
// RULE_04: Duty writes while counting are latched, applied at old duty match.
// RULE_05: Latched duty applies only after three clocks since the write.
// RULE_06: Clearing run enable returns event and output to default.
// RULE_07: Carrier mode: low-width compare sets low phase, high-width sets high.
// RULE_08: Software must not rewrite low-width compare while carrier runs.
// RULE_09: Carrier compares low-width first; each match events, clears, inverts, swaps.
// RULE_10: Carrier period is N+M+2 clocks, high phase M+1 clocks.
// RULE_11: Remote-enable and active carrier-enable select low, high or carrier output.
// RULE_12: Carrier enable is buffer (read/write) plus read-only active bit.
// RULE_13: Envelope match event is synchronised; sync event is an output.
// RULE_14: Buffer copies to active on second clock after sync event rise.
// RULE_15: Software waits two clocks between buffer writes.
// RULE_16: Software writes next buffer value after the sync event.
// RULE_17: Active going 1 starts carrier at its first rising edge.
// RULE_18: Active going 0 during high phase keeps output high to phase end.
// RULE_19: Software uses carrier compare values 01H to FFH only.
// RULE_20: Count clock must exceed six times envelope count clock.
// RULE_21: Software rewrites high-width compare on every restart.
// RULE_22: Software sets remote-output enable before starting the count.
// RULE_23: Software does not change remote-output enable while running.
// RULE_24: Read-only status bit reads 0 disabled, 1 enabled.
// RULE_25: Default output low and match event inactive.
`ifndef IRC_DEFS_VH
`define IRC_DEFS_VH
`define IRC_OFF_CTRL 5'h00
`define IRC_OFF_CMP0 5'h04
`define IRC_OFF_CMP1 5'h08
`define IRC_OFF_CARR 5'h0C
`define IRC_OFF_STAT 5'h10
`define IRC_CTRL_RUN 0
`define IRC_CTRL_MODE 1
`define IRC_CARR_ACTIVE 0
`define IRC_CARR_BUFFER 1
`define IRC_CARR_REMOTE 2
`define IRC_RST_BYTE 8'h00
`define IRC_DUTY_AGE_MIN 2'h3
`define IRC_CNT_ONE 8'h01
`endif

// *** tb/irc_env_model.sv ***
// Purpose: envelope timer stand-in
// Assumes: event held a few count clocks
// Notes: idle level low
`timescale 1ns/100ps
`default_nettype none
module irc_env_model (
  // Clock
  input wire logic clk_in,
  // Envelope event
  output var logic ev_out
);
  initial ev_out = 1'h0;
  task automatic fire(input int hold);
    @(posedge clk_in);
    ev_out <= 1'h1;
    repeat (hold) @(posedge clk_in);
    ev_out <= 1'h0;
  endtask
endmodule
`default_nettype wire

// *** tb/irc_timer_sva.sv ***
// Purpose: port checker for irc_timer
// Assumes: one clock domain
// Notes: bound below
`timescale 1ns/100ps
`default_nettype none
module irc_timer_sva (
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  // Bus
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_READDATA_OUT,
  input wire logic AVS_WAITREQUEST_OUT,
  // Timer
  input wire logic ENVELOPE_MATCH_EVENT_IN,
  input wire logic ENVELOPE_SYNC_EVENT_OUT,
  input wire logic TIMER_OUTPUT_PIN_OUT,
  input wire logic COMPARE_MATCH_EVENT_OUT
);
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_N_IN);
  sequence s_req;
    $rose(AVS_READ_IN || AVS_WRITE_IN);
  endsequence
  a_wait_once: assert property (s_req |-> AVS_WAITREQUEST_OUT ##1 !AVS_WAITREQUEST_OUT)
    else $error("wait cycle");
  a_idle_nowait: assert property (!(AVS_READ_IN || AVS_WRITE_IN) |-> !AVS_WAITREQUEST_OUT)
    else $error("idle wait");
  a_rdata_hold: assert property (!AVS_READ_IN |=> $stable(AVS_READDATA_OUT))
    else $error("read data moved");
  a_sync_single: assert property (ENVELOPE_SYNC_EVENT_OUT |=> !ENVELOPE_SYNC_EVENT_OUT)
    else $error("sync width");
  a_sync_cause: assert property (ENVELOPE_SYNC_EVENT_OUT |-> $past(ENVELOPE_MATCH_EVENT_IN, 2))
    else $error("sync cause");
  a_match_single: assert property (COMPARE_MATCH_EVENT_OUT |=> !COMPARE_MATCH_EVENT_OUT)
    else $error("match width");
  a_reset_quiet: assert property ($rose(RST_N_IN) |-> !COMPARE_MATCH_EVENT_OUT && !ENVELOPE_SYNC_EVENT_OUT)
    else $error("events after reset");
  a_start_low: assert property ($rose(RST_N_IN) |-> !TIMER_OUTPUT_PIN_OUT [*3])
    else $error("pin after reset");
endmodule
bind irc_timer irc_timer_sva i_irc_timer_sva (.*);
`default_nettype wire

// *** tb/test_irc_timer.sv ***
// Purpose: self-checking bench for irc_timer
// Assumes: one wait cycle per transfer
// Notes: envelope from irc_env_model
`timescale 1ns/100ps
`default_nettype none
module test_irc_timer;
  logic CLOCK_IN = 1'h0;
  logic RST_N_IN = 1'h0;
  logic [4:0] AVS_ADDRESS_IN = 5'h00;
  logic AVS_READ_IN = 1'h0;
  logic AVS_WRITE_IN = 1'h0;
  logic [31:0] AVS_WRITEDATA_IN = 32'h0;
  logic [3:0] AVS_BYTEENABLE_IN = 4'hF;
  wire [31:0] AVS_READDATA_OUT;
  wire AVS_WAITREQUEST_OUT;
  wire ENVELOPE_MATCH_EVENT_IN;
  wire ENVELOPE_SYNC_EVENT_OUT;
  wire TIMER_OUTPUT_PIN_OUT;
  wire COMPARE_MATCH_EVENT_OUT;
  int num_errors = 0;
  int n_checks = 0;
  logic [31:0] rd;
  int hi;
  int lo;
  int n_match = 0;
  int n_sync = 0;
  int base;
  always #5 CLOCK_IN = ~CLOCK_IN;
  // Event pulse counters
  always @(posedge CLOCK_IN) begin
    if (COMPARE_MATCH_EVENT_OUT === 1'h1) n_match++;
    if (ENVELOPE_SYNC_EVENT_OUT === 1'h1) n_sync++;
  end
  irc_timer i_irc_timer (.*);
  irc_env_model i_irc_env_model (.clk_in(CLOCK_IN), .ev_out(ENVELOPE_MATCH_EVENT_IN));
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge CLOCK_IN);
    AVS_ADDRESS_IN <= a;
    AVS_WRITEDATA_IN <= {24'h0, d};
    AVS_WRITE_IN <= w;
    AVS_READ_IN <= !w;
    // Hold until waitrequest is sampled low at a rising edge
    do begin
      @(posedge CLOCK_IN);
    end while (AVS_WAITREQUEST_OUT !== 1'h0);
    rd = AVS_READDATA_OUT;
    AVS_WRITE_IN <= 1'h0;
    AVS_READ_IN <= 1'h0;
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
    bus(1'h0, a, 8'h00);
    chk(e, rd);
  endtask
  // Cycles the pin stays at level v, capped
  task automatic run_len(input logic v, output int c);
    c = 0;
    while (TIMER_OUTPUT_PIN_OUT === v && c < 600) begin
      @(negedge CLOCK_IN);
      c++;
    end
  endtask
  task automatic meas;
    @(negedge CLOCK_IN);
    run_len(1'h1, hi);
    run_len(1'h0, hi);
    run_len(1'h1, hi);
    run_len(1'h0, lo);
  endtask
  task automatic t_regs;
    rd_chk(5'h00, 32'h0);
    rd_chk(5'h10, 32'h0);
    bus(1'h1, 5'h0C, 8'h03);
    rd_chk(5'h0C, 32'h2);
    rd_chk(5'h14, 32'h0);
  endtask
  task automatic t_pwm;
    bus(1'h1, 5'h04, 8'h04);
    bus(1'h1, 5'h08, 8'h01);
    bus(1'h1, 5'h00, 8'h01);
    @(negedge CLOCK_IN);
    chk(1'h0, TIMER_OUTPUT_PIN_OUT);
    meas;
    chk(2, hi);
    chk(3, lo);
    bus(1'h1, 5'h08, 8'h02);
    meas;
    meas;
    chk(3, hi);
    chk(2, lo);
    base = n_match;
    repeat (10) @(negedge CLOCK_IN);
    chk(2, n_match - base);
    bus(1'h1, 5'h00, 8'h00);
    repeat (2) @(negedge CLOCK_IN);
    chk(2'h0, {TIMER_OUTPUT_PIN_OUT, COMPARE_MATCH_EVENT_OUT});
  endtask
  task automatic t_car;
    bus(1'h1, 5'h04, 8'h02);
    bus(1'h1, 5'h08, 8'h01);
    bus(1'h1, 5'h0C, 8'h06);
    bus(1'h1, 5'h00, 8'h03);
    base = n_sync;
    i_irc_env_model.fire(4);
    repeat (4) @(posedge CLOCK_IN);
    chk(1, n_sync - base);
    rd_chk(5'h0C, 32'h7);
    meas;
    chk(2, hi);
    chk(3, lo);
    base = n_match;
    repeat (10) @(negedge CLOCK_IN);
    chk(4, n_match - base);
    bus(1'h1, 5'h0C, 8'h04);
    i_irc_env_model.fire(4);
    repeat (8) @(negedge CLOCK_IN);
    run_len(1'h0, lo);
    chk(600, lo);
    bus(1'h1, 5'h00, 8'h02);
    bus(1'h1, 5'h0C, 8'h02);
    bus(1'h1, 5'h08, 8'h01);
    bus(1'h1, 5'h00, 8'h03);
    i_irc_env_model.fire(4);
    repeat (6) @(negedge CLOCK_IN);
    chk(1'h1, TIMER_OUTPUT_PIN_OUT);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge CLOCK_IN);
    RST_N_IN <= 1'h1;
    t_regs;
    t_pwm;
    t_car;
    stop_test;
  end
  initial begin
    #100000;
    num_errors++;
    stop_test;
  end
endmodule
`default_nettype wire
